// File: rtl/gsh_pkg.sv
// shared constants and types of the generic serial host port
// assumes one core clock; serial pins are sampled, never used as clocks
package gsh_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SCLK_MAX_MHZ = 48;
  localparam int MAX_FRAME_BYTES = 2048;
  localparam int CMD_BITS = 32;
  localparam int STATUS_BITS = 32;
  localparam int DELAY_UNIT_BITS = 8;
  // command word layout
  localparam int CMD_WRITE_BIT = 31;
  localparam int CMD_INCR_BIT = 30;
  localparam int CMD_FUNC_LSB = 28;
  localparam int CMD_ADDR_LSB = 11;
  localparam int CMD_ADDR_W = 17;
  localparam int CMD_LEN_W = 11;
  // function numbers
  localparam logic [1:0] FN_BUS = 2'h0;
  localparam logic [1:0] FN_BACKPLANE = 2'h1;
  // bus-function register byte addresses
  localparam logic [16:0] CFG_ADDR = 17'h00000;
  localparam logic [16:0] DELAY_ADDR = 17'h00001;
  localparam logic [16:0] STATCTL_ADDR = 17'h00002;
  // configuration bits
  localparam int WORD32_BIT = 0;
  localparam int BIGEND_BIT = 1;
  localparam int HSPEED_BIT = 4;
  localparam int IRQPOL_BIT = 5;
  localparam int WAKE_BIT = 7;
  localparam int STATEN_BIT = 0;
  localparam int IRQWST_BIT = 1;
  localparam int DELAYALL_BIT = 2;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h30;
  localparam logic [7:0] DELAY_RST = 8'h04;
  localparam logic [7:0] STATCTL_RST = 8'h01;
  localparam logic [1:0] SYNC_HIGH_RST = 2'h3;

  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_DELAY, PH_DATA, PH_STATUS, PH_DONE} gsh_phase_type;

  // function-side status, 31 bits packed in wire order from bit 30 down; the wire word adds a zero at bit 7
  typedef struct packed {
    logic [10:0] secLen;
    logic secAvail;
    logic [10:0] priLen;
    logic priAvail;
    logic secRxReady;
    logic priRxReady;
    logic secInt;
    logic priInt;
    logic overflow;
    logic underflow;
    logic noData;
  } gsh_status_type;

  typedef struct packed {
    logic write;
    logic [1:0] func;
    logic [16:0] addr;
    logic [31:0] data;
  } gsh_req_type;
endpackage : gsh_pkg

// File: rtl/gsh_port.sv
// device end of the generic serial host port: command, data and status
// assumes sclk, csN and serialDataIn are asynchronous pins, slow enough
// that each half period spans at least three core clocks
`timescale 1ns/10ps
module gsh_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic serialDataIn,
  output logic dataOut,
  output logic hostInterruptLine,
  output logic reqValid,
  output gsh_pkg::gsh_req_type req,
  input wire logic [31:0] rdData,
  input wire gsh_pkg::gsh_status_type status,
  input wire logic hostEvent,
  input wire logic chipReady,
  output logic wakeRequest,
  output logic transferActive
);
  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] sclkSync;
    logic [1:0] dinSync;
    logic sclkPrev;
    gsh_pkg::gsh_phase_type phase;
    logic [31:0] cmd;
    logic [14:0] bitCnt;
    logic [31:0] inShift;
    logic [31:0] outShift;
    logic [31:0] holdWord;
    logic loadPend;
    logic readHeld;
    logic fetchLocal;
    logic fetchStat;
    logic [16:0] addr;
    logic [7:0] cfg;
    logic [7:0] respDelay;
    logic [7:0] statCtl;
    logic reqValid;
    gsh_pkg::gsh_req_type req;
    logic irqLine;
    logic active;
  } gsh_port_state_type;

  gsh_port_state_type s;
  gsh_port_state_type n;

  // byte reversal inside a 16- or 32-bit word
  function automatic logic [31:0] swapBytes(input logic [31:0] w, input logic w32);
    swapBytes = w32 ? {w[7:0], w[15:8], w[23:16], w[31:24]} : {16'h0000, w[7:0], w[15:8]};
  endfunction : swapBytes

  logic rise;
  logic fall;
  logic din;
  logic csLow;
  logic w32;
  logic bigEnd;
  logic hiSpeed;
  logic launch;
  logic wordEnd;
  logic dataEnd;
  logic arrive;
  logic [31:0] rawWord;
  logic [31:0] newWord;
  logic [31:0] regWord;
  logic [31:0] statWord;
  logic [31:0] cmdFull;
  logic [31:0] dataWord;
  logic [11:0] halfWords;
  logic [14:0] dataBitsM1;
  logic [14:0] delayBitsM1;
  logic [16:0] nextAddr;
  logic needDelay;
  logic irqPend;
  logic [16:0] byteAddr;

  // pin sampling and derived timing terms
  always_comb begin
    rise = s.sclkSync[1] & ~s.sclkPrev;
    fall = ~s.sclkSync[1] & s.sclkPrev;
    din = s.dinSync[1];
    csLow = ~s.csSync[1];
    w32 = s.cfg[gsh_pkg::WORD32_BIT];
    bigEnd = s.cfg[gsh_pkg::BIGEND_BIT];
    hiSpeed = s.cfg[gsh_pkg::HSPEED_BIT];
    launch = hiSpeed ? rise : fall;
    cmdFull = {s.cmd[30:0], din};
    // zero count means a full 2 KB frame; odd counts round up to 16 bits
    if (s.cmd[gsh_pkg::CMD_LEN_W-1:0] == 11'h000) begin
      halfWords = 12'h400;
    end else begin
      halfWords = ({1'b0, s.cmd[gsh_pkg::CMD_LEN_W-1:0]} + 12'h001) >> 1;
    end
    dataBitsM1 = {halfWords[10:0], 4'h0} - 15'h0001;
    delayBitsM1 = {4'h0, s.respDelay, 3'h0} - 15'h0001;
    needDelay = (s.respDelay != 8'h00) &&
      ((cmdFull[29:28] == gsh_pkg::FN_BACKPLANE) || s.statCtl[gsh_pkg::DELAYALL_BIT]);
    wordEnd = (s.bitCnt[3:0] == 4'hF) && (!w32 || s.bitCnt[4]);
    dataEnd = (s.bitCnt == dataBitsM1);
    if (s.cmd[gsh_pkg::CMD_INCR_BIT]) begin
      nextAddr = s.addr + (w32 ? 17'h00004 : 17'h00002);
    end else begin
      nextAddr = s.addr;
    end
  end

  // reply words: bus-function registers, status, function read data
  always_comb begin
    regWord = 32'h00000000;
    if (s.addr < 17'h00004) begin
      regWord = {8'h00, s.statCtl, s.respDelay, s.cfg} >> {s.addr[1:0], 3'h0};
    end
    statWord = {status.secLen, status.secAvail, status.priLen, status.priAvail, 1'b0,
      status.secRxReady, status.priRxReady, status.secInt, status.priInt,
      status.overflow, status.underflow, status.noData};
    arrive = (s.reqValid & ~s.req.write) | s.fetchLocal | s.fetchStat;
    rawWord = s.fetchLocal ? regWord : rdData;
    rawWord = bigEnd ? swapBytes(rawWord, w32) : rawWord;
    if (s.fetchStat) begin
      newWord = statWord;
    end else begin
      newWord = w32 ? rawWord : {rawWord[15:0], 16'h0000};
    end
    dataWord = {s.inShift[30:0], din};
    dataWord = bigEnd ? swapBytes(dataWord, w32) : dataWord;
    irqPend = (hostEvent & (~s.statCtl[gsh_pkg::STATEN_BIT] | s.statCtl[gsh_pkg::IRQWST_BIT]))
      | (s.cfg[gsh_pkg::WAKE_BIT] & chipReady);
  end

  // transfer sequencer
  always_comb begin
    n = s;
    byteAddr = 17'h00000;
    n.csSync = {s.csSync[0], csN};
    n.sclkSync = {s.sclkSync[0], sclk};
    n.dinSync = {s.dinSync[0], serialDataIn};
    n.sclkPrev = s.sclkSync[1];
    n.reqValid = 1'b0;
    n.fetchLocal = 1'b0;
    n.fetchStat = 1'b0;
    // interrupt line follows the programmed polarity
    n.irqLine = s.cfg[gsh_pkg::IRQPOL_BIT] ? irqPend : ~irqPend;
    // output shifter: a fetched word replaces the shifter at once in
    // high-speed mode, otherwise it waits for the falling edge
    if (arrive) begin
      if (hiSpeed) begin
        n.outShift = newWord;
      end else begin
        n.holdWord = newWord;
        n.loadPend = 1'b1;
      end
    end else if (launch) begin
      if (s.loadPend) begin
        n.outShift = s.holdWord;
        n.loadPend = 1'b0;
      end else begin
        n.outShift = {s.outShift[30:0], 1'b0};
      end
    end
    if (!csLow) begin
      // a read command may wait any time for its data phase
      if (!s.readHeld) begin
        if (!s.cmd[gsh_pkg::CMD_WRITE_BIT] && s.bitCnt == 15'h0000 &&
            (s.phase == gsh_pkg::PH_DELAY || s.phase == gsh_pkg::PH_DATA)) begin
          n.readHeld = 1'b1;
        end else begin
          n.phase = gsh_pkg::PH_IDLE;
        end
      end
    end else if (s.readHeld) begin
      n.readHeld = 1'b0;
    end else if (s.phase == gsh_pkg::PH_IDLE) begin
      n.phase = gsh_pkg::PH_CMD;
      n.bitCnt = 15'h0000;
      n.outShift = 32'h00000000;
      n.loadPend = 1'b0;
    end else if (rise) begin
      n.bitCnt = s.bitCnt + 15'h0001;
      case (s.phase)
        gsh_pkg::PH_CMD: begin
          n.cmd = cmdFull;
          if (s.bitCnt == 15'(gsh_pkg::CMD_BITS - 1)) begin
            n.bitCnt = 15'h0000;
            n.addr = cmdFull[gsh_pkg::CMD_ADDR_LSB +: gsh_pkg::CMD_ADDR_W];
            n.req.func = cmdFull[gsh_pkg::CMD_FUNC_LSB +: 2];
            n.req.addr = n.addr;
            n.req.write = cmdFull[gsh_pkg::CMD_WRITE_BIT];
            if (cmdFull[gsh_pkg::CMD_WRITE_BIT]) begin
              n.phase = gsh_pkg::PH_DATA;
            end else if (needDelay) begin
              n.phase = gsh_pkg::PH_DELAY;
            end else begin
              n.phase = gsh_pkg::PH_DATA;
              n.fetchLocal = (n.req.func == gsh_pkg::FN_BUS);
              n.reqValid = (n.req.func != gsh_pkg::FN_BUS);
            end
          end
        end
        gsh_pkg::PH_DELAY: begin
          if (s.bitCnt == delayBitsM1) begin
            n.bitCnt = 15'h0000;
            n.phase = gsh_pkg::PH_DATA;
            n.fetchLocal = (s.cmd[gsh_pkg::CMD_FUNC_LSB +: 2] == gsh_pkg::FN_BUS);
            n.reqValid = (s.cmd[gsh_pkg::CMD_FUNC_LSB +: 2] != gsh_pkg::FN_BUS);
            n.req.addr = s.addr;
          end
        end
        gsh_pkg::PH_DATA: begin
          n.inShift = {s.inShift[30:0], din};
          if (wordEnd || dataEnd) begin
            n.addr = nextAddr;
            n.req.addr = nextAddr;
            if (s.cmd[gsh_pkg::CMD_WRITE_BIT]) begin
              if (s.cmd[gsh_pkg::CMD_FUNC_LSB +: 2] == gsh_pkg::FN_BUS) begin
                // bus-function writes land in the local registers
                for (int k = 0; k < 4; k++) begin
                  byteAddr = s.addr + 17'(k);
                  if (k < 2 || w32) begin
                    if (byteAddr == gsh_pkg::CFG_ADDR) begin
                      n.cfg = dataWord[8*k +: 8];
                    end else if (byteAddr == gsh_pkg::DELAY_ADDR) begin
                      n.respDelay = dataWord[8*k +: 8];
                    end else if (byteAddr == gsh_pkg::STATCTL_ADDR) begin
                      n.statCtl = dataWord[8*k +: 8];
                    end
                  end
                end
              end else begin
                n.reqValid = 1'b1;
                n.req.addr = s.addr;
                n.req.data = dataWord;
              end
            end else if (!dataEnd) begin
              n.fetchLocal = (s.cmd[gsh_pkg::CMD_FUNC_LSB +: 2] == gsh_pkg::FN_BUS);
              n.reqValid = (s.cmd[gsh_pkg::CMD_FUNC_LSB +: 2] != gsh_pkg::FN_BUS);
            end
          end
          if (dataEnd) begin
            n.bitCnt = 15'h0000;
            if (s.statCtl[gsh_pkg::STATEN_BIT]) begin
              n.phase = gsh_pkg::PH_STATUS;
              n.fetchStat = 1'b1;
            end else begin
              n.phase = gsh_pkg::PH_DONE;
            end
          end
        end
        gsh_pkg::PH_STATUS: begin
          if (s.bitCnt == 15'(gsh_pkg::STATUS_BITS - 1)) begin
            n.phase = gsh_pkg::PH_DONE;
          end
        end
        default: begin
          n.bitCnt = s.bitCnt;
        end
      endcase
    end
    // request fields move only with a request pulse, so a user that
    // latches them late still sees the last request
    if (n.reqValid) begin
      n.req.write = n.cmd[gsh_pkg::CMD_WRITE_BIT];
      n.req.func = n.cmd[gsh_pkg::CMD_FUNC_LSB +: 2];
    end else begin
      n.req = s.req;
    end
    n.active = (n.phase != gsh_pkg::PH_IDLE);
  end

  // state register; sync chains reset to the idle pin levels
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.csSync <= gsh_pkg::SYNC_HIGH_RST;
      s.cfg <= gsh_pkg::CFG_RST;
      s.respDelay <= gsh_pkg::DELAY_RST;
      s.statCtl <= gsh_pkg::STATCTL_RST;
    end else begin
      s <= n;
    end
  end

  // every output is a bit of the state register
  assign dataOut = s.outShift[31];
  assign hostInterruptLine = s.irqLine;
  assign reqValid = s.reqValid;
  assign req = s.req;
  assign wakeRequest = s.cfg[gsh_pkg::WAKE_BIT];
  assign transferActive = s.active;
endmodule : gsh_port

// File: testbench/gsh_port_chk.sv
// checker of the serial host port, watching the top-level ports only
// assumes the bind at the foot of this file
`timescale 1ns/10ps
module gsh_port_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic serialDataIn,
  input wire logic dataOut,
  input wire logic hostInterruptLine,
  input wire logic reqValid,
  input wire gsh_pkg::gsh_req_type req,
  input wire logic [31:0] rdData,
  input wire gsh_pkg::gsh_status_type status,
  input wire logic hostEvent,
  input wire logic chipReady,
  input wire logic wakeRequest,
  input wire logic transferActive
);
  logic [3:0] quiet_ff;
  logic sclkQ_ff;
  logic csnQ_ff;
  // cycles since a pin edge; saturates so long idles cost nothing
  always_ff @(posedge core_clk) begin
    sclkQ_ff <= sclk;
    csnQ_ff <= csN;
    if (rst || sclk != sclkQ_ff || csN != csnQ_ff) quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_req_pulse: assert property (reqValid |=> !reqValid)
    else $error("request pulse longer than one cycle");
  chk_bus_local: assert property (reqValid |-> req.func != gsh_pkg::FN_BUS)
    else $error("bus function access left the port");
  chk_req_active: assert property (reqValid |-> transferActive)
    else $error("request outside a transfer");
  chk_req_edge: assert property (reqValid |-> !$past(csN, 4) && $past(sclk, 3))
    else $error("request not tied to a clock edge under select");
  chk_dout_timing: assert property ($changed(dataOut) |-> quiet_ff <= 4'h7)
    else $error("data out moved away from a link edge");
  chk_active_sel: assert property ($rose(transferActive) |-> !$past(csN, 2))
    else $error("transfer began without chip select");
  chk_req_stands: assert property (!reqValid |-> $stable(req))
    else $error("request fields changed without a request");
  chk_wake_write: assert property ($changed(wakeRequest) |-> $past(transferActive))
    else $error("wake request changed outside a transfer");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !reqValid && !transferActive && !dataOut && !wakeRequest)
    else $error("outputs not quiet after reset");
  cover property (reqValid && req.write);
  cover property (reqValid && !req.write);
  cover property ($rose(wakeRequest));
endmodule : gsh_port_chk
bind gsh_port gsh_port_chk chk (.core_clk(core_clk), .rst(rst), .csN(csN), .sclk(sclk),
  .serialDataIn(serialDataIn), .dataOut(dataOut), .hostInterruptLine(hostInterruptLine),
  .reqValid(reqValid), .req(req), .rdData(rdData), .status(status), .hostEvent(hostEvent),
  .chipReady(chipReady), .wakeRequest(wakeRequest), .transferActive(transferActive));

// File: testbench/gsh_host.sv
// host model: drives chip select, link clock and data in
// assumes the link clock stands low between frames
`timescale 1ns/10ps
module gsh_host #(
  parameter int HALF = 10
) (
  input wire logic core_clk,
  output logic csN,
  output logic sclk,
  output logic serialDataIn,
  input wire logic dataOut
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    serialDataIn = 1'b0;
  end
  // one frame; 160 ns period stays far below the ceiling
  task automatic frame(input logic [31:0] cmd, input logic [63:0] wd, input int nd,
      input int nr, output logic [127:0] rd);
    int i;
    logic b;
    rd = '0;
    @(posedge core_clk);
    csN <= 1'b0;
    for (i = 0; i < 32 + nd + nr; i++) begin
      b = ~serialDataIn; // unused line toggles so nothing matches by luck
      if (i < 32) b = cmd[31 - i]; // command first, msb leading
      else if (i < 32 + nd) b = wd[nd + 31 - i];
      serialDataIn <= b; // half a period ahead of the rising edge
      repeat (HALF) @(posedge core_clk);
      sclk <= 1'b1;
      rd = {rd[126:0], dataOut}; // host reads on rising edges
      repeat (HALF) @(posedge core_clk);
      sclk <= 1'b0; // next bit goes out on the falling edge
    end
    repeat (HALF) @(posedge core_clk);
    csN <= 1'b1;
    serialDataIn <= ~serialDataIn;
    repeat (HALF) @(posedge core_clk);
  endtask : frame
endmodule : gsh_host

// File: testbench/test_gsh_port.sv
// self-checking bench of the serial host port through a host model
// assumes gsh_host on the pins and the checker bound in
`timescale 1ns/10ps
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin nFail++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module test_gsh_port;
  localparam logic [30:0] ST = 31'h2AB55A5A;
  localparam logic [31:0] SW = {ST[30:7], 1'b0, ST[6:0]};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic csN, sclk, serialDataIn, dataOut, hostInterruptLine, reqValid;
  logic wakeRequest, transferActive;
  logic hostEvent = 1'b0;
  logic chipReady = 1'b0;
  logic [31:0] rdData = 32'h9E375A1C;
  gsh_pkg::gsh_status_type status = ST;
  gsh_pkg::gsh_req_type req, lastReq;
  logic [127:0] rd;
  int nFail = 0;
  int testsRun = 0;
  int nReq = 0;
  int n0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  gsh_port DUT (.core_clk(core_clk), .rst(rst), .csN(csN), .sclk(sclk),
    .serialDataIn(serialDataIn), .dataOut(dataOut), .hostInterruptLine(hostInterruptLine),
    .reqValid(reqValid), .req(req), .rdData(rdData), .status(status), .hostEvent(hostEvent),
    .chipReady(chipReady), .wakeRequest(wakeRequest), .transferActive(transferActive));
  gsh_host host (.core_clk(core_clk), .csN(csN), .sclk(sclk),
    .serialDataIn(serialDataIn), .dataOut(dataOut));
  // keeps the latest request; rdData is held so it is ready in the cycle of the request pulse
  always @(posedge core_clk) begin
    cycles++;
    if (reqValid === 1'b1) begin
      lastReq = req;
      nReq++;
    end
    if (cycles == 40000) begin
      nFail++;
      final_report();
    end
  end
  function automatic logic [31:0] mk(input logic w, input logic [1:0] fn,
      input logic [16:0] a, input logic [10:0] n);
    return {w, 1'b1, fn, a, n};
  endfunction : mk
  task automatic pause();
    repeat (8) @(posedge core_clk);
  endtask : pause
  task automatic final_report();
    $display("checks %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(dataOut, 1'b0)
    `CHK(wakeRequest, 1'b0)
    `CHK(transferActive, 1'b0)
    $display("test reset done");
    host.frame(mk(1'b1, 2'h2, 17'h00010, 11'h002), 64'hA5C3, 16, 32, rd);
    `CHK(lastReq.write, 1'b1)
    `CHK(lastReq.func, 2'h2)
    `CHK(lastReq.addr, 17'h00010)
    `CHK(lastReq.data[15:0], 16'hA5C3)
    `CHK(rd[31:0], SW)
    $display("test write16 done");
    host.frame(mk(1'b0, 2'h2, 17'h00100, 11'h004), 64'h0, 0, 64, rd);
    `CHK(rd[63:0], {16'h5A1C, 16'h5A1C, SW})
    `CHK(lastReq.write, 1'b0)
    host.frame(mk(1'b0, gsh_pkg::FN_BACKPLANE, 17'h00040, 11'h002), 64'h0, 0, 80, rd);
    `CHK(rd[79:0], {32'h0, 16'h5A1C, SW})
    $display("test reads done");
    n0 = nReq;
    host.frame(mk(1'b1, gsh_pkg::FN_BUS, gsh_pkg::CFG_ADDR, 11'h001), 64'h00B3, 16, 32, rd);
    `CHK(nReq, n0)
    `CHK(wakeRequest, 1'b1)
    hostEvent <= 1'b1;
    pause();
    `CHK(hostInterruptLine, 1'b0)
    chipReady <= 1'b1;
    pause();
    `CHK(hostInterruptLine, 1'b1)
    hostEvent <= 1'b0;
    chipReady <= 1'b0;
    $display("test wake done");
    host.frame(mk(1'b1, 2'h2, 17'h00020, 11'h004), 64'h11223344, 32, 32, rd);
    `CHK(lastReq.data, 32'h44332211)
    `CHK(rd[31:0], SW)
    $display("test write32 done");
    host.frame(mk(1'b1, gsh_pkg::FN_BUS, gsh_pkg::CFG_ADDR, 11'h004), 64'hB3040000, 32, 32, rd);
    hostEvent <= 1'b1;
    pause();
    `CHK(hostInterruptLine, 1'b1)
    hostEvent <= 1'b0;
    host.frame(mk(1'b0, 2'h2, 17'h00100, 11'h004), 64'h0, 0, 64, rd);
    `CHK(rd[63:32], 32'h1C5A379E)
    `CHK(rd[31:0], 32'h0)
    $display("test status off done");
    // opposite edges (cfg A3), then a read split by a chip select gap
    host.frame(mk(1'b1, gsh_pkg::FN_BUS, gsh_pkg::CFG_ADDR, 11'h004), 64'hA3040000, 32, 0,
      rd);
    host.frame(mk(1'b0, 2'h2, 17'h00100, 11'h004), 64'h0, 0, 0, rd);
    host.frame(32'h0, 64'h0, 0, 32, rd);
    `CHK(rd[63:32], 32'h1C5A379E)
    `CHK(rd[31:0], 32'h0)
    `CHK(lastReq.addr, 17'h00100)
    $display("test split read done");
    final_report();
  end
endmodule : test_gsh_port
